// *** core/ctc_pkg.sv ***
package ctc_pkg;

	localparam int unsigned CLK_PERIOD_NS   = 50;
	localparam int unsigned TICK_NS         = 1_000_000;
	localparam int unsigned TICK_CYCLES     = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned INTERVAL_BASE_S = 21;
	localparam int unsigned INTERVAL_MAX_S  = 168;
	localparam int unsigned CONV_MS         = 5;
	localparam int unsigned TICK_MS         = TICK_NS / 1_000_000;
	localparam int unsigned INTERVAL_BASE_TICKS = INTERVAL_BASE_S * 1000 / TICK_MS;
	localparam int unsigned CONV_TICKS      = (CONV_MS + TICK_MS - 1) / TICK_MS;
	localparam int unsigned PRE_W           = 24;
	localparam int unsigned IVL_W           = 18;
	localparam int unsigned CODE_W          = 12;
	localparam int unsigned CELL_W          = 4;
	localparam int unsigned CODE_UV_X10     = 25;

	typedef enum logic [1:0] {
		SEQ_WAIT_FIRST,
		SEQ_CONV_FIRST,
		SEQ_WAIT_SECOND,
		SEQ_CONV_SECOND
	} ctc_seq_t;

	typedef struct packed {
		logic             cell_undervolt;
		logic             above_low_temp;
		logic             below_high_temp;
		logic             timeout_expired;
		logic [CODE_W-1:0] batt_code;
	} ctc_sense_t;

	typedef struct packed {
		logic [1:0]        interval_sel;
		logic              neg_slope;
		logic [CELL_W-1:0] cells_minus_one;
	} ctc_cfg_t;

	typedef struct packed {
		logic              fast;
		logic              terminated;
		logic              armed;
		logic              start_pending;
		logic              cold_wait;
		logic              prev_cold_ok;
		logic              converting;
		ctc_seq_t          seq;
		logic [PRE_W-1:0]  prescale;
		logic [IVL_W-1:0]  ticks;
		logic [CODE_W-1:0] first_code;
	} ctc_state_t;

endpackage

// *** core/ctc_charge_termination_control.sv ***
`timescale 1ns/1ps
module ctc_charge_termination_control #(
	parameter int unsigned P_TICK_CYCLES = ctc_pkg::TICK_CYCLES
) (
	input  wire logic                        REF_CLK_IN,
	input  wire logic                        RESET_IN,
	input  wire logic                        BATT_INSERT_IN,
	input  wire ctc_pkg::ctc_sense_t         SENSE_IN,
	input  wire ctc_pkg::ctc_cfg_t           CFG_IN,
	output logic                             FAST_CHARGE_OUT,
	output logic                             TERMINATED_OUT,
	output logic                             CONVERTING_OUT
);

	ctc_pkg::ctc_state_t state;
	ctc_pkg::ctc_state_t next_state;

	function automatic logic [ctc_pkg::IVL_W-1:0] interval_ticks(input logic [1:0] sel);
		interval_ticks = ctc_pkg::IVL_W'(ctc_pkg::INTERVAL_BASE_TICKS) << sel;
	endfunction

	function automatic logic slope_stop(input logic [ctc_pkg::CODE_W-1:0] first,
			input logic [ctc_pkg::CODE_W-1:0] second, input ctc_pkg::ctc_cfg_t cfg);
		logic [ctc_pkg::CODE_W:0] cells;
		cells = (ctc_pkg::CODE_W+1)'(cfg.cells_minus_one) + (ctc_pkg::CODE_W+1)'(1);
		if (cfg.neg_slope) begin
			slope_stop = ({1'b0, first} >= cells) && ({1'b0, second} <= {1'b0, first} - cells);
		end else begin
			slope_stop = (second == first);
		end
	endfunction

	// End of a conversion, shared by both conversion states
	function automatic logic conv_done(input logic [ctc_pkg::IVL_W-1:0] ticks);
		conv_done = (ticks == ctc_pkg::IVL_W'(ctc_pkg::CONV_TICKS - 1));
	endfunction

	logic tick;
	logic window_ok;
	logic cold_rise;

	always_comb begin
		tick      = (state.prescale == ctc_pkg::PRE_W'(P_TICK_CYCLES - 1));
		window_ok = SENSE_IN.above_low_temp && SENSE_IN.below_high_temp
			&& !SENSE_IN.cell_undervolt;
		cold_rise = SENSE_IN.above_low_temp && !state.prev_cold_ok;
		next_state = state;
		next_state.prev_cold_ok = SENSE_IN.above_low_temp;
		next_state.prescale = tick ? '0 : state.prescale + ctc_pkg::PRE_W'(1);

		// Slope sequencer
		if (tick) begin
			next_state.ticks = state.ticks + ctc_pkg::IVL_W'(1);
			unique case (state.seq)
				ctc_pkg::SEQ_WAIT_FIRST, ctc_pkg::SEQ_WAIT_SECOND: begin
					if (state.ticks == interval_ticks(CFG_IN.interval_sel) - 1'b1) begin
						next_state.ticks = '0;
						next_state.converting = 1'b1;
						next_state.seq = (state.seq == ctc_pkg::SEQ_WAIT_FIRST)
							? ctc_pkg::SEQ_CONV_FIRST : ctc_pkg::SEQ_CONV_SECOND;
					end
				end
				ctc_pkg::SEQ_CONV_FIRST: begin
					if (conv_done(state.ticks)) begin
						next_state.ticks = '0;
						next_state.converting = 1'b0;
						next_state.first_code = SENSE_IN.batt_code;
						next_state.seq = ctc_pkg::SEQ_WAIT_SECOND;
					end
				end
				ctc_pkg::SEQ_CONV_SECOND: begin
					if (conv_done(state.ticks)) begin
						next_state.ticks = '0;
						next_state.converting = 1'b0;
						next_state.seq = ctc_pkg::SEQ_WAIT_FIRST;
						if (state.fast && slope_stop(state.first_code, SENSE_IN.batt_code,
								CFG_IN)) begin
							next_state.terminated = 1'b1;
						end
					end
				end
			endcase
		end

		// Charge state: fast, trickle or terminated
		if (state.start_pending || BATT_INSERT_IN) begin
			next_state.start_pending = 1'b0;
			next_state.terminated    = 1'b0;
			next_state.fast          = 1'b0;
			next_state.armed         = SENSE_IN.below_high_temp;
			next_state.cold_wait     = !SENSE_IN.above_low_temp;
			if (BATT_INSERT_IN) begin
				next_state.seq        = ctc_pkg::SEQ_WAIT_FIRST;
				next_state.ticks      = '0;
				next_state.prescale   = '0;
				next_state.converting = 1'b0;
			end
		end else begin
			if (state.cold_wait && cold_rise) begin
				next_state.cold_wait = 1'b0;
			end
			if (state.fast && !SENSE_IN.below_high_temp) begin
				next_state.terminated = 1'b1;
			end
			if (SENSE_IN.timeout_expired) begin
				next_state.terminated = 1'b1;
			end
			if (next_state.terminated) begin
				next_state.fast  = 1'b0;
				next_state.armed = 1'b0;
			end else if (state.fast && SENSE_IN.cell_undervolt) begin
				next_state.fast = 1'b0;
			end else if (!state.fast && state.armed && !next_state.cold_wait
					&& window_ok) begin
				next_state.fast = 1'b1;
				next_state.armed = !state.cold_wait;
			end
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (RESET_IN) begin
			state <= '0;
			state.start_pending <= 1'b1;
			state.seq <= ctc_pkg::SEQ_WAIT_FIRST;
		end else begin
			state <= next_state;
		end
	end

	always_comb begin
		FAST_CHARGE_OUT = state.fast;
		TERMINATED_OUT  = state.terminated;
		CONVERTING_OUT  = state.converting;
	end

endmodule

// *** tb/ctc_batt_model.sv ***
`timescale 1ns/1ps
module ctc_batt_model (
	input	wire logic		hot_in,
	input	wire logic		cold_in,
	input	wire logic		uv_in,
	input	wire logic		tmo_in,
	input	wire logic [11:0]	code_in,
	output	ctc_pkg::ctc_sense_t	sense_out
);
	assign sense_out = {uv_in, !cold_in, !hot_in, tmo_in, code_in};
endmodule

// *** tb/ctc_checker.sv ***
`timescale 1ns/1ps
module ctc_checker #(
	parameter int unsigned P_TICK_CYCLES = 1
) (
	input	wire logic		REF_CLK_IN,
	input	wire logic		RESET_IN,
	input	wire logic		BATT_INSERT_IN,
	input	wire ctc_pkg::ctc_sense_t	SENSE_IN,
	input	wire logic		FAST_CHARGE_OUT,
	input	wire logic		TERMINATED_OUT,
	input	wire logic		CONVERTING_OUT
);
	wire f = FAST_CHARGE_OUT;
	wire t = TERMINATED_OUT;
	wire i = BATT_INSERT_IN;
	wire c = CONVERTING_OUT;
	wire hot = !SENSE_IN.below_high_temp;
	default clocking @(posedge REF_CLK_IN); endclocking
	default disable iff (RESET_IN);
	a_two_states: assert property (!(f && t)) else $error("fast and ended");
	a_hot_ends: assert property (f && hot && !i |=> !f && t) else $error("hot");
	a_timeout_ends: assert property (f && SENSE_IN.timeout_expired && !i |=> !f && t)
		else $error("timeout");
	a_end_holds: assert property (t && !i |=> t && !f) else $error("resumed");
	a_cold_holds: assert property (!f && !SENSE_IN.above_low_temp |=> !f) else $error("cold");
	a_hot_holds: assert property (!f && hot |=> !f) else $error("hot start");
	a_uv_holds: assert property (!f && SENSE_IN.cell_undervolt |=> !f) else $error("uv");
	a_conv_len: assert property ($fell(c) && !$past(i) |-> $past(c, 5 * P_TICK_CYCLES)
		&& !$past(c, 5 * P_TICK_CYCLES + 1)) else $error("conversion length");
	c_end: cover property ($rose(t));
	c_conv: cover property ($fell(c));
	c_fast: cover property ($rose(f));
endmodule
bind ctc_charge_termination_control ctc_checker #(.P_TICK_CYCLES(P_TICK_CYCLES)) chk_u (
	.REF_CLK_IN, .RESET_IN, .BATT_INSERT_IN, .SENSE_IN, .FAST_CHARGE_OUT,
	.TERMINATED_OUT, .CONVERTING_OUT);

// *** tb/tb_charge_termination_control.sv ***
`timescale 1ns/1ps
module tb_charge_termination_control;
	logic	clk = 1'b0, rst = 1'b1, ins = 1'b0, hot = 1'b0, cold = 1'b0, tmo = 1'b0, uv = 1'b0;
	ctc_pkg::ctc_sense_t	sense;
	ctc_pkg::ctc_cfg_t	cfg = '{2'h0, 1'b0, 4'h1};
	logic	fast, term, conv;
	logic [11:0]	code = 12'h03e8;
	int	n, first, fails = 0, checks = 0;
	always #25 clk = ~clk;
	ctc_batt_model batt_u (.hot_in(hot), .cold_in(cold), .uv_in(uv), .tmo_in(tmo),
		.code_in(code), .sense_out(sense));
	ctc_charge_termination_control #(.P_TICK_CYCLES(1)) dut_u (.REF_CLK_IN(clk),
		.RESET_IN(rst), .BATT_INSERT_IN(ins), .SENSE_IN(sense), .CFG_IN(cfg),
		.FAST_CHARGE_OUT(fast), .TERMINATED_OUT(term), .CONVERTING_OUT(conv));
	task chk(input string s, input logic e, input logic g);
		@(negedge clk);
		checks++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s expected %b seen %b", s, e, g);
		end
		@(posedge clk);
	endtask
	task summarize;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task go(input int k);
		repeat (k) @(posedge clk);
	endtask
	// Counts falling edges until the conversion flag reaches v
	task wt(input logic v);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (conv !== v && n < 30000);
	endtask
	task do_reset(input logic h, input logic c);
		@(posedge clk);
		rst <= 1'b1;
		hot <= h;
		cold <= c;
		go(4);
		rst <= 1'b0;
		go(4);
	endtask
	task t_hot;
		do_reset(1'b1, 1'b0);
		chk("hot start", 1'b0, fast);
		hot <= 1'b0;
		go(3);
		chk("cooled", 1'b0, fast);
		do_reset(1'b0, 1'b0);
		chk("start", 1'b1, fast);
		hot <= 1'b1;
		go(3);
		chk("hot end", 1'b1, term);
		hot <= 1'b0;
		uv <= 1'b1;
		go(3);
		uv <= 1'b0;
		go(3);
		chk("no resume", 1'b0, fast);
	endtask
	task t_cold;
		do_reset(1'b0, 1'b1);
		chk("cold", 1'b0, fast);
		cold <= 1'b0;
		go(3);
		chk("warmed", 1'b1, fast);
		tmo <= 1'b1;
		go(1);
		tmo <= 1'b0;
		go(2);
		chk("timeout", 1'b1, term);
		ins <= 1'b1;
		go(1);
		ins <= 1'b0;
		go(3);
		chk("inserted", 1'b1, fast);
	endtask
	task t_slope;
		do_reset(1'b0, 1'b0);
		wt(1'b1);
		first = n;
		wt(1'b0);
		chk("interval", 1'b1, first > 20990 && first < 21010);
		chk("conversion", 1'b1, n == 5);
		chk("mid", 1'b1, fast);
		wt(1'b1);
		wt(1'b0);
		chk("slope end", 1'b1, term);
	endtask
	// Second sample two codes lower with two cells programmed
	task t_neg;
		cfg.neg_slope <= 1'b1;
		do_reset(1'b0, 1'b0);
		wt(1'b1);
		wt(1'b0);
		code <= 12'h03e6;
		chk("neg mid", 1'b1, fast);
		wt(1'b1);
		wt(1'b0);
		chk("neg end", 1'b1, term);
	endtask
	initial begin
		t_hot();
		t_cold();
		t_slope();
		t_neg();
		summarize();
	end
	initial begin
		#4_600_000;
		fails++;
		summarize();
	end
endmodule
